/* core/sdc_pkg.sv */
// shared constants for the video reference clock and mode control block
package sdc_pkg;
    // ************************************************************
    // debounced input vector layout
    // ************************************************************
    localparam int IN_OP_MODE   = 0;
    localparam int IN_GROUP     = 1;
    localparam int IN_RATE      = 2;
    localparam int IN_SD_HD     = 3;
    localparam int IN_FMT_LO    = 4;
    localparam int IN_FMT_HI    = 6;
    localparam int IN_PAGE_BTN  = 7;
    localparam int IN_GEN_BTN   = 8;
    localparam int IN_CHK_BTN   = 9;
    localparam int IN_COUNT     = 10;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_FREQ_MHZ     = 125;
    localparam int DEBOUNCE_TIME_US = 10000;
    localparam int DEBOUNCE_CYCLES  = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;
    // ************************************************************
    // encodings and reset values
    // ************************************************************
    typedef enum logic {
        MODE_PATTERN = 1'b0,
        MODE_PASS    = 1'b1
    } sdc_mode_type;
    // pathological: matrix, equaliser, pll; bars: 100%, 75%, smpte
    typedef enum logic [1:0] {
        PAT_FIRST  = 2'h0,
        PAT_SECOND = 2'h1,
        PAT_THIRD  = 2'h2
    } sdc_pattern_type;
    // page 1/2 meaning depends on mode, see top module
    typedef enum logic [1:0] {
        PAGE_MODE   = 2'h0,
        PAGE_STAT_A = 2'h1,
        PAGE_STAT_B = 2'h2,
        PAGE_TIME   = 2'h3
    } sdc_page_type;
    localparam logic [5:0] STD_SEL_RESET = 6'h00;
endpackage : sdc_pkg

/* core/sdc_refclk_ctrl.sv */
// reference clock steering and switch/button mode decoding
//
// Function
// - receiver rate flag steers the receive clock generator controls
// - free-run generators get six-bit standard select for SD or HD rate
// - pass-through receive reference only needs lock; ppm offset ok
// - pass-through transmit clock must equal recovered clock exactly
// - pass-through: receiver timing drives transmit generator genlock
// - pattern mode: both generators free-run, genlock never used
// - receive reference via fabric, transmit reference via dedicated pins
// - receive and transmit take different reference sources
// - mode switch picks pass-through or pattern, reinterprets controls
// - display offers four pages whose meaning depends on mode
// - any control change shows related page; page button steps page
// - group switch picks bars or check-fields; separate gen/chk buttons
// - sd/hd switch, three format bits, rate factor switch select format
// - this logic drives every clock chip control input itself
// - each pattern press advances that side's pattern cyclically
`timescale 1ns/1ns
module sdc_refclk_ctrl #(
    parameter int         DEBOUNCE_CYCLES = sdc_pkg::DEBOUNCE_CYCLES,
    // clock chip standard codes; arbitrary defaults, set per board
    parameter logic [5:0] SD_STD_CODE     = 6'h01,
    parameter logic [5:0] HD_STD_CODE     = 6'h02
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       op_mode_switch,
    input  wire logic       pattern_group_switch,
    input  wire logic       rate_factor_switch,
    input  wire logic       sd_hd_switch,
    input  wire logic [2:0] format_switch,
    input  wire logic       page_button,
    input  wire logic       gen_pattern_button,
    input  wire logic       chk_pattern_button,
    input  wire logic       rx_rate_is_high,
    input  wire logic       rx_locked,
    input  wire logic       rx_field,
    input  wire logic       rx_vblank,
    input  wire logic       rx_hblank,
    output logic [5:0]      rx_clkgen_video_std_sel,
    output logic            rx_clkgen_genlock,
    output logic [5:0]      tx_clkgen_video_std_sel,
    output logic            tx_clkgen_genlock,
    output logic            tx_clkgen_field,
    output logic            tx_clkgen_vblank,
    output logic            tx_clkgen_hblank,
    output logic            rx_refclk_from_fabric,
    output logic            tx_refclk_from_pins,
    output logic            pass_through_mode,
    output logic            pattern_group,
    output logic            hd_format,
    output logic [2:0]      format_sel,
    output logic            rate_factor_sel,
    output logic [1:0]      gen_pattern,
    output logic [1:0]      chk_pattern,
    output logic [1:0]      display_page
);
    localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

    if (DEBOUNCE_CYCLES < 1) begin : g_bad
        $error("DEBOUNCE_CYCLES must be at least 1");
    end

    // equal codes would leave SD and HD at one frequency
    if (SD_STD_CODE == HD_STD_CODE) begin : g_bad_std
        $error("SD and HD standard codes must differ");
    end

    logic [sdc_pkg::IN_COUNT-1:0] raw_in;
    logic [sdc_pkg::IN_COUNT-1:0] deb;
    assign raw_in = {chk_pattern_button, gen_pattern_button, page_button,
                     format_switch, sd_hd_switch, rate_factor_switch,
                     pattern_group_switch, op_mode_switch};

    // ************************************************************
    // synchronise and debounce
    // ************************************************************
    genvar gi;
    for (gi = 0; gi < sdc_pkg::IN_COUNT; gi++) begin : g_in
        logic [2:0]    sync_reg;
        logic [2:0]    sync_next;
        logic [CW-1:0] cnt_reg;
        logic [CW-1:0] cnt_next;
        logic          deb_reg;
        logic          deb_next;
        always_comb begin
            sync_next = {sync_reg[1:0], raw_in[gi]};
            cnt_next  = cnt_reg;
            deb_next  = deb_reg;
            if (sync_reg[2] != sync_reg[1] || sync_reg[2] == deb_reg) begin
                cnt_next = '0;
            end else if (cnt_reg == CW'(DEBOUNCE_CYCLES - 1)) begin
                cnt_next = '0;
                deb_next = sync_reg[2];
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sync_reg <= 3'h0;
                cnt_reg  <= '0;
                deb_reg  <= 1'b0;
            end else if (clk_en) begin
                sync_reg <= sync_next;
                cnt_reg  <= cnt_next;
                deb_reg  <= deb_next;
            end
        end
        assign deb[gi] = deb_reg;
    end

    // ************************************************************
    // control state
    // ************************************************************
    logic [sdc_pkg::IN_COUNT-1:0] prev_reg, prev_next;
    logic [5:0] rx_sel_reg, rx_sel_next, tx_sel_reg, tx_sel_next;
    logic       tx_gl_reg, tx_gl_next;
    logic [2:0] tx_ref_reg, tx_ref_next;
    logic       mode_reg, mode_next;
    sdc_pkg::sdc_pattern_type gen_reg, gen_next, chk_reg, chk_next;
    sdc_pkg::sdc_page_type    page_reg, page_next;
    logic [4:0] fmt_reg, fmt_next;
    logic       grp_reg, grp_next;
    logic       route_reg, route_next;
    logic       page_step, gen_step, chk_step, sw_change;

    function automatic sdc_pkg::sdc_pattern_type step_pat(
        input sdc_pkg::sdc_pattern_type p);
        case (p)
            sdc_pkg::PAT_FIRST:  step_pat = sdc_pkg::PAT_SECOND;
            sdc_pkg::PAT_SECOND: step_pat = sdc_pkg::PAT_THIRD;
            default:             step_pat = sdc_pkg::PAT_FIRST;
        endcase
    endfunction : step_pat

    always_comb begin
        prev_next = deb;
        route_next = 1'b1;
        page_step = deb[sdc_pkg::IN_PAGE_BTN]
                    & ~prev_reg[sdc_pkg::IN_PAGE_BTN];
        gen_step  = deb[sdc_pkg::IN_GEN_BTN] & ~prev_reg[sdc_pkg::IN_GEN_BTN];
        chk_step  = deb[sdc_pkg::IN_CHK_BTN] & ~prev_reg[sdc_pkg::IN_CHK_BTN];
        sw_change = deb[sdc_pkg::IN_FMT_HI:sdc_pkg::IN_RATE]
                    != prev_reg[sdc_pkg::IN_FMT_HI:sdc_pkg::IN_RATE];
        mode_next = deb[sdc_pkg::IN_OP_MODE];
        grp_next  = deb[sdc_pkg::IN_GROUP];
        // format fields: fmt bits, sd/hd, rate factor
        fmt_next  = {deb[sdc_pkg::IN_FMT_HI:sdc_pkg::IN_FMT_LO],
                     deb[sdc_pkg::IN_SD_HD], deb[sdc_pkg::IN_RATE]};
        gen_next  = gen_step ? step_pat(gen_reg) : gen_reg;
        chk_next  = chk_step ? step_pat(chk_reg) : chk_reg;
        rx_sel_next = rx_rate_is_high ? HD_STD_CODE : SD_STD_CODE;
        // genlock to receiver timing in pass-through
        tx_gl_next  = mode_next && rx_locked;
        tx_ref_next = tx_gl_next ? {rx_field, rx_vblank, rx_hblank} : 3'h0;
        // pattern mode free-runs at switch-chosen rate
        if (mode_next == sdc_pkg::MODE_PASS) begin
            tx_sel_next = rx_sel_next;
        end else begin
            tx_sel_next = deb[sdc_pkg::IN_SD_HD] ? HD_STD_CODE : SD_STD_CODE;
        end
        page_next = page_reg;
        if (mode_next != mode_reg) begin
            page_next = sdc_pkg::PAGE_MODE;
        end else if (gen_step || sw_change) begin
            page_next = sdc_pkg::PAGE_STAT_A;
        end else if (chk_step) begin
            page_next = mode_reg ? sdc_pkg::PAGE_STAT_B
                                 : sdc_pkg::PAGE_STAT_B;
        end else if (grp_next != grp_reg) begin
            page_next = mode_reg ? sdc_pkg::PAGE_STAT_B
                                 : sdc_pkg::PAGE_STAT_A;
        end else if (page_step) begin
            case (page_reg)
                sdc_pkg::PAGE_MODE:   page_next = sdc_pkg::PAGE_STAT_A;
                sdc_pkg::PAGE_STAT_A: page_next = sdc_pkg::PAGE_STAT_B;
                sdc_pkg::PAGE_STAT_B: page_next = sdc_pkg::PAGE_TIME;
                default:              page_next = sdc_pkg::PAGE_MODE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg   <= '0;
            mode_reg   <= 1'b0;
            grp_reg    <= 1'b0;
            fmt_reg    <= 5'h00;
            gen_reg    <= sdc_pkg::PAT_FIRST;
            chk_reg    <= sdc_pkg::PAT_FIRST;
            rx_sel_reg <= sdc_pkg::STD_SEL_RESET;
            tx_sel_reg <= sdc_pkg::STD_SEL_RESET;
            tx_gl_reg  <= 1'b0;
            tx_ref_reg <= 3'h0;
            page_reg   <= sdc_pkg::PAGE_MODE;
            route_reg  <= 1'b0;
        end else if (clk_en) begin
            prev_reg   <= prev_next;
            mode_reg   <= mode_next;
            grp_reg    <= grp_next;
            fmt_reg    <= fmt_next;
            gen_reg    <= gen_next;
            chk_reg    <= chk_next;
            rx_sel_reg <= rx_sel_next;
            tx_sel_reg <= tx_sel_next;
            tx_gl_reg  <= tx_gl_next;
            tx_ref_reg <= tx_ref_next;
            page_reg   <= page_next;
            route_reg  <= route_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // every clock chip control driven here
    assign rx_clkgen_video_std_sel = rx_sel_reg;
    // receive generator never genlocked; lock reference only
    assign rx_clkgen_genlock       = 1'b0;
    assign tx_clkgen_video_std_sel = tx_sel_reg;
    assign tx_clkgen_genlock       = tx_gl_reg;
    assign tx_clkgen_field         = tx_ref_reg[2];
    assign tx_clkgen_vblank        = tx_ref_reg[1];
    assign tx_clkgen_hblank        = tx_ref_reg[0];
    // distinct reference paths; quadrant pins are shared
    assign rx_refclk_from_fabric   = route_reg;
    assign tx_refclk_from_pins     = route_reg;
    assign pass_through_mode       = mode_reg;
    assign pattern_group           = grp_reg;
    assign format_sel              = fmt_reg[4:2];
    assign hd_format               = fmt_reg[1];
    assign rate_factor_sel         = fmt_reg[0];
    assign gen_pattern             = gen_reg;
    assign chk_pattern             = chk_reg;
    assign display_page            = page_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rx_std_follow: assert property (
        (rst_n && clk_en) |=> rx_clkgen_video_std_sel ==
            ($past(rx_rate_is_high) ? HD_STD_CODE : SD_STD_CODE))
        else $error("receive standard select does not follow rate");
    a_pattern_no_lock: assert property (
        !pass_through_mode |-> !tx_clkgen_genlock && !rx_clkgen_genlock)
        else $error("genlock active in pattern mode");
    a_pattern_tx_std: assert property (
        // sampled rst_n keeps the release edge, still in reset, out
        (rst_n && clk_en && !deb[sdc_pkg::IN_OP_MODE]) |=>
            tx_clkgen_video_std_sel ==
            ($past(deb[sdc_pkg::IN_SD_HD]) ? HD_STD_CODE : SD_STD_CODE))
        else $error("transmit free-run select wrong");
    a_genlock_ref: assert property (
        (clk_en && deb[sdc_pkg::IN_OP_MODE] && rx_locked) |=>
            tx_clkgen_genlock && tx_clkgen_field == $past(rx_field)
            && tx_clkgen_hblank == $past(rx_hblank))
        else $error("transmit generator not genlocked to receiver");
    a_pass_tx_std: assert property (
        pass_through_mode |-> tx_clkgen_video_std_sel ==
            rx_clkgen_video_std_sel)
        else $error("transmit rate differs from receive in pass-through");
    a_gen_step: assert property (
        (clk_en && gen_step && gen_pattern == 2'h2) |=> gen_pattern == 2'h0)
        else $error("generator pattern does not wrap");
    a_pattern_range: assert property (
        chk_pattern != 2'h3 && gen_pattern != 2'h3)
        else $error("pattern index out of range");
    a_step_single: assert property (
        (clk_en && gen_step) |=> !(clk_en && gen_step))
        else $error("press produced more than one step");
    a_page_step: assert property (
        (clk_en && page_step && mode_next == mode_reg && !gen_step
         && !chk_step && !sw_change && grp_next == grp_reg
         && display_page == 2'h3) |=> display_page == 2'h0)
        else $error("page button does not wrap page");
    a_mode_page: assert property (
        (clk_en && mode_next != mode_reg) |=> display_page == 2'h0)
        else $error("mode change does not show mode page");
endmodule : sdc_refclk_ctrl

/* tb/sdc_rx_model.sv */
// receiver side model: rate flag, lock and frame timing
`timescale 1ns/1ns
module sdc_rx_model #(
    parameter logic [5:0] SD_CODE = 6'h01,
    parameter logic [5:0] HD_CODE = 6'h02
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       want_hd,
    input  wire logic       want_lock,
    input  wire logic [5:0] ref_sel,
    output logic            rx_rate_is_high,
    output logic            rx_locked,
    output logic            rx_field,
    output logic            rx_vblank,
    output logic            rx_hblank
);
    logic [7:0] pos_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {rx_rate_is_high, rx_locked, pos_reg} <= '0;
            {rx_field, rx_vblank, rx_hblank} <= 3'h0;
        end else begin
            rx_rate_is_high <= want_hd;
            // locks only on the matching reference
            rx_locked <= want_lock && ref_sel == (want_hd ? HD_CODE : SD_CODE);
            pos_reg <= pos_reg + 8'h01;
            // timing only while locked; moves every few cycles
            rx_hblank <= rx_locked && pos_reg[1];
            rx_vblank <= rx_locked && pos_reg[3];
            rx_field <= rx_locked && pos_reg[5];
        end
    end
endmodule : sdc_rx_model

/* tb/tb_top.sv */
// self-checking bench for the clock steering and mode control block
`timescale 1ns/1ns
module tb_top;
    localparam logic [5:0] SD_CODE = 6'h05;
    localparam logic [5:0] HD_CODE = 6'h2A;
    logic clk, rst_n, clk_en, want_hd, want_lock;
    logic op_mode_switch, pattern_group_switch, rate_factor_switch;
    logic sd_hd_switch, page_button, gen_pattern_button;
    logic chk_pattern_button, rx_rate_is_high, rx_locked;
    logic rx_field, rx_vblank, rx_hblank, hd_format, rate_factor_sel;
    logic rx_clkgen_genlock, tx_clkgen_genlock, tx_clkgen_field;
    logic tx_clkgen_vblank, tx_clkgen_hblank, rx_refclk_from_fabric;
    logic tx_refclk_from_pins, pass_through_mode, pattern_group;
    logic [2:0] format_switch, format_sel, fmt, prev;
    logic [5:0] rx_clkgen_video_std_sel, tx_clkgen_video_std_sel;
    logic [1:0] gen_pattern, chk_pattern, display_page;
    logic [1:0] exp_page, exp_gen, exp_chk;
    int num_errors, total_checks, cycles;

    sdc_refclk_ctrl #(.DEBOUNCE_CYCLES(4), .SD_STD_CODE(SD_CODE),
        .HD_STD_CODE(HD_CODE)) u_dut (.*);
    sdc_rx_model #(.SD_CODE(SD_CODE), .HD_CODE(HD_CODE)) u_rx (
        .ref_sel(rx_clkgen_video_std_sel), .*);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [5:0] exp_std(input logic hd);
        return hd ? HD_CODE : SD_CODE;
    endfunction : exp_std
    function automatic logic [1:0] next_pat(input logic [1:0] p);
        return (p == 2'h2) ? 2'h0 : p + 2'h1;
    endfunction : next_pat
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    // debounce is 4 in sim, so 16 edges leave ample margin
    task automatic settle();
        repeat (16) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic press(input int b);
        @(posedge clk);
        page_button <= (b == 0);
        gen_pattern_button <= (b == 1);
        chk_pattern_button <= (b == 2);
        settle();
        @(posedge clk);
        {page_button, gen_pattern_button, chk_pattern_button} <= 3'h0;
        settle();
    endtask : press

    // ************************************************************
    // clock, timeout, main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'hb9a1a632));
        {rst_n, want_hd, want_lock, op_mode_switch, pattern_group_switch} = '0;
        {rate_factor_switch, sd_hd_switch, format_switch} = '0;
        {page_button, gen_pattern_button, chk_pattern_button} = '0;
        clk_en = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(rx_clkgen_video_std_sel, sdc_pkg::STD_SEL_RESET);
        check({rx_refclk_from_fabric, tx_refclk_from_pins}, 2'h0);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check({rx_refclk_from_fabric, tx_refclk_from_pins}, 2'h3);
        check({display_page, gen_pattern, pass_through_mode}, 5'h0);
        // pattern mode: both generators free-run at any receiver rate
        repeat (6) begin
            @(posedge clk);
            want_hd <= 1'($urandom);
            want_lock <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            check(rx_clkgen_video_std_sel, exp_std(want_hd));
            check({rx_clkgen_genlock, tx_clkgen_genlock}, 2'h0);
            check(tx_clkgen_hblank, 1'b0);
            check(tx_clkgen_video_std_sel, exp_std(1'b0));
        end
        fmt = 3'($urandom);
        @(posedge clk);
        {sd_hd_switch, rate_factor_switch, format_switch} <= {2'h3, fmt};
        settle();
        check({hd_format, rate_factor_sel, format_sel}, {2'h3, fmt});
        check(display_page, 2'h1);
        check(tx_clkgen_video_std_sel, HD_CODE);
        exp_gen = 2'h0;
        exp_chk = 2'h0;
        repeat (4) begin
            press(1);
            exp_gen = next_pat(exp_gen);
            check({gen_pattern, display_page}, {exp_gen, 2'h1});
        end
        repeat (3) begin
            press(2);
            exp_chk = next_pat(exp_chk);
            check({chk_pattern, display_page}, {exp_chk, 2'h2});
        end
        @(posedge clk);
        pattern_group_switch <= 1'b1;
        settle();
        check({pattern_group, display_page}, 3'h5);
        check(gen_pattern, exp_gen);
        exp_page = 2'h1;
        repeat (4) begin
            press(0);
            exp_page = exp_page + 2'h1;
            check(display_page, exp_page);
        end
        // short glitch, then a long press while the clock enable is low
        @(posedge clk);
        gen_pattern_button <= 1'b1;
        repeat (2) @(posedge clk);
        gen_pattern_button <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        gen_pattern_button <= 1'b1;
        repeat (20) @(posedge clk);
        gen_pattern_button <= 1'b0;
        clk_en <= 1'b1;
        settle();
        check(gen_pattern, exp_gen);
        // pass-through: genlock to receiver timing
        @(posedge clk);
        {op_mode_switch, want_hd} <= 2'h2;
        settle();
        check({pass_through_mode, display_page}, 3'h4);
        check({rx_locked, tx_clkgen_genlock}, 2'h3);
        prev = {rx_field, rx_vblank, rx_hblank};
        repeat (40) begin
            @(negedge clk);
            check({tx_clkgen_field, tx_clkgen_vblank, tx_clkgen_hblank},
                prev);
            check(tx_clkgen_video_std_sel, rx_clkgen_video_std_sel);
            prev = {rx_field, rx_vblank, rx_hblank};
        end
        @(posedge clk);
        {pattern_group_switch, want_hd} <= 2'h1;
        settle();
        check(display_page, 2'h2);
        check(tx_clkgen_video_std_sel, HD_CODE);
        check(rx_clkgen_genlock, 1'b0);
        @(posedge clk);
        want_lock <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check({tx_clkgen_genlock, tx_clkgen_vblank}, 2'h0);
        report_and_stop();
    end
endmodule : tb_top
